/* File: shared/srb_pkg.sv */
// Constants and types for the software reset and boot select block.
package srb_pkg;
	// Timing: the clock period and the reset hold time, both in nanoseconds.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned RESET_HOLD_NS = 80;
	localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TA_OPEN_CYCLES = 4;
	localparam int unsigned HOLD_CNT_W = 4;
	localparam int unsigned TA_CNT_W = 3;

	// Register indexes; the byte address on the bus is four times the index.
	localparam int unsigned IDX_W = 10;
	localparam logic [IDX_W-1:0] IDX_CHIP_CONTROL = 10'h09f;
	localparam logic [IDX_W-1:0] IDX_AUX_FLAGS = 10'h0a2;
	localparam logic [IDX_W-1:0] IDX_BOOT_CONFIG = 10'h0b0;
	localparam logic [IDX_W-1:0] IDX_TIMED_ACCESS = 10'h0b1;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0b2;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0b3;
	localparam logic [IDX_W-1:0] IDX_CORE_STATE = 10'h0b4;

	// Field positions.
	localparam int unsigned CC_TRIGGER = 7;
	localparam int unsigned CC_IAP_FAIL = 6;
	localparam int unsigned CC_BOOT_SEL = 1;
	localparam int unsigned CC_IAP_EN = 0;
	localparam int unsigned AUX_SOFT_FLAG = 7;
	localparam int unsigned AUX_PIN_FLAG = 6;
	localparam int unsigned CFG_BOOT_DEFAULT = 7;
	localparam int unsigned CS_RAM_OK = 0;
	localparam int unsigned CS_TA_OPEN = 1;
	localparam int unsigned CS_SOFT_CAUSE = 2;
	localparam int unsigned CS_IN_RESET = 3;

	// Reset values, masks and key values.
	localparam logic [7:0] AUX_RW_MASK = 8'h39;
	localparam logic [7:0] AUX_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'hff;
	localparam logic [7:0] TA_KEY_FIRST = 8'haa;
	localparam logic [7:0] TA_KEY_SECOND = 8'h55;
	localparam logic [7:0] STACK_RESET = 8'h07;
	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam logic [15:0] FETCH_RESET = 16'h0000;

	// Interrupt event bits.
	localparam int unsigned EV_W = 4;
	localparam int unsigned EV_SOFT_DONE = 0;
	localparam int unsigned EV_PIN_RESET = 1;
	localparam int unsigned EV_WDT_RESET = 2;
	localparam int unsigned EV_DENIED = 3;

	// Reset sequencer states.
	typedef enum logic [1:0] {
		SRB_RUN = 2'b01,
		SRB_HOLD = 2'b10
	} srb_seq_t;
endpackage : srb_pkg

/* File: src/srb_top.sv */
// Software reset trigger, reset source flags and boot block selection with an APB register port.
// Summary of operation
// [R1] Writing one to the trigger bit resets the whole system like a pin reset.
// [R2] Software opens the timed window with 0xaa then 0x55 before triggering.
// [R3] The triggering write is the last instruction; the core stalls at once.
// [R4] The trigger bit is write-only and clears itself when the reset ends.
// [R5] A software reset sets the software reset flag, bit 7 of aux_flags.
// [R6] That flag survives other resets; software clears it by writing zero. Here a power-on reset (RST) clears it.
// [R7] Boot select zero fetches from application_rom, one from loader_rom, at 0000H.
// [R8] Non-software resets load boot select from inverted config bit; software reset keeps it.
// [R9] Config bit one means application_rom, zero means loader_rom.
// [R10] The configuration byte reads all ones in its default state.
// [R11] At release the boot block follows boot select, never the config bit.
// [R12] RAM survives non-power-on resets; after power-on it counts as undefined.
// [R13] The fetch address is forced to 0000H for the whole reset.
// [R14] Every reset loads the stack pointer with 07H.
// [R15] Reset returns registers to initial values; reset flags keep their own rules.
// [R16] After any reset peripherals and interrupt sources are disabled.
// [R17] After reset port latches hold FFH and pins are input only.
// [R18] A trigger write without an open timed window is ignored.
`timescale 1ns/1ps
`default_nettype none
module srb_top #(
	parameter int unsigned HOLD_LEN = srb_pkg::RESET_HOLD_CYCLES,
	parameter int unsigned TA_LEN = srb_pkg::TA_OPEN_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_RESET_N,
	input wire logic WDT_TIMEOUT,
	output logic SYS_RESET,
	output logic CORE_STALL,
	output logic BOOT_LOADER,
	output logic [15:0] FETCH_ADDR,
	output logic [7:0] STACK_INIT,
	output logic [7:0] PORT_LATCH,
	output logic PORT_INPUT_ONLY,
	output logic PERIPH_DISABLE,
	output logic RAM_VALID,
	output logic IRQ
);
	import srb_pkg::*;

	srb_seq_t seq;
	logic [HOLD_CNT_W-1:0] hold_cnt;
	logic cause_soft;
	logic trigger;
	logic [2:0] pin_sync;
	logic pin_low;
	logic ta_first;
	logic [TA_CNT_W-1:0] ta_cnt;
	logic ta_open;
	logic boot_sel;
	logic iap_fail;
	logic iap_en;
	logic soft_flag;
	logic pin_flag;
	logic [7:0] aux_rw;
	logic [7:0] boot_cfg;
	logic ram_ok;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [EV_W-1:0] events;
	logic [IDX_W-1:0] idx;
	logic addr_hit;
	logic access;
	logic wr;
	logic rd;
	logic cc_wr;
	logic cc_ok;
	logic trig_accept;
	logic enter_hw;
	logic hold_done;
	logic [7:0] rd_mux;

	// Bus decode; the slave answers with no wait states.
	assign idx = PADDR[IDX_W+1:2];
	assign access = PSEL & PENABLE;
	assign addr_hit = (PADDR[1:0] == 2'b00) && (idx == IDX_CHIP_CONTROL || idx == IDX_AUX_FLAGS
		|| idx == IDX_BOOT_CONFIG || idx == IDX_TIMED_ACCESS || idx == IDX_IRQ_STATUS
		|| idx == IDX_IRQ_MASK || idx == IDX_CORE_STATE);
	assign PREADY = 1'b1;
	assign PSLVERR = access & ~addr_hit;
	assign wr = access & PWRITE & addr_hit;
	assign rd = access & ~PWRITE & addr_hit;

	// A chip_control write only counts while the timed window is open.
	assign cc_wr = wr && idx == IDX_CHIP_CONTROL;
	assign cc_ok = cc_wr & ta_open; // [R18]
	assign trig_accept = cc_ok & PWDATA[CC_TRIGGER] & (seq == SRB_RUN); // [R1]
	assign enter_hw = pin_low | WDT_TIMEOUT;
	// Release only when no hardware request stands, so a late watchdog pulse cannot latch the boot block early.
	assign hold_done = (seq == SRB_HOLD) && hold_cnt == '0 && !enter_hw;

	// Reset state outputs; the core stalls in the very cycle the trigger is accepted.
	assign SYS_RESET = (seq == SRB_HOLD);
	assign CORE_STALL = SYS_RESET | trig_accept; // [R3]
	assign PERIPH_DISABLE = SYS_RESET; // [R16]
	assign PORT_INPUT_ONLY = SYS_RESET; // [R17]
	assign RAM_VALID = ram_ok;
	assign IRQ = |(irq_status & irq_mask);

	// Pin reset passes three flops; a level counts only once the last two agree.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_sync <= 3'h7;
			pin_low <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], EXT_RESET_N};
			if (pin_sync[1] == pin_sync[2]) begin
				pin_low <= ~pin_sync[2];
			end
		end
	end

	// Timed access unlock: the two keys in order open a short window, any chip_control write closes it.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ta_first <= 1'b0;
			ta_cnt <= '0;
		end else begin
			if (wr && idx == IDX_TIMED_ACCESS) begin
				if (PWDATA[7:0] == TA_KEY_FIRST) begin
					ta_first <= 1'b1;
				end else begin
					ta_first <= 1'b0;
					if (ta_first && PWDATA[7:0] == TA_KEY_SECOND) begin
						ta_cnt <= TA_CNT_W'(TA_LEN); // [R2]
					end
				end
			end else if (cc_wr) begin
				ta_cnt <= '0;
			end else if (ta_cnt != '0) begin
				ta_cnt <= ta_cnt - 1'b1;
			end
		end
	end
	assign ta_open = (ta_cnt != '0);

	// Reset sequencer. Hardware sources win over a software trigger and turn a running soft reset into a hard one.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			seq <= SRB_RUN;
			hold_cnt <= '0;
			cause_soft <= 1'b0;
			trigger <= 1'b0;
		end else begin
			unique case (seq)
				SRB_RUN: begin
					if (enter_hw) begin
						seq <= SRB_HOLD;
						cause_soft <= 1'b0;
						hold_cnt <= HOLD_CNT_W'(HOLD_LEN - 1);
					end else if (trig_accept) begin
						seq <= SRB_HOLD; // [R1]
						cause_soft <= 1'b1;
						trigger <= 1'b1;
						hold_cnt <= HOLD_CNT_W'(HOLD_LEN - 1);
					end
				end
				SRB_HOLD: begin
					if (enter_hw) begin
						cause_soft <= 1'b0;
						hold_cnt <= HOLD_CNT_W'(HOLD_LEN - 1);
					end else if (hold_cnt == '0) begin
						seq <= SRB_RUN;
						trigger <= 1'b0; // [R4]
					end else begin
						hold_cnt <= hold_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	// Boot select and the plain control bits; only hardware resets reload boot select.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			boot_sel <= ~CFG_RESET[CFG_BOOT_DEFAULT]; // [R8] [R10]
			iap_fail <= 1'b0;
			iap_en <= 1'b0;
		end else if (enter_hw) begin
			boot_sel <= ~boot_cfg[CFG_BOOT_DEFAULT]; // [R8] [R9]
			iap_fail <= 1'b0;
			iap_en <= 1'b0;
		end else if (SYS_RESET) begin
			iap_fail <= 1'b0; // [R15]
			iap_en <= 1'b0;
		end else if (cc_ok) begin
			boot_sel <= PWDATA[CC_BOOT_SEL];
			iap_fail <= PWDATA[CC_IAP_FAIL];
			iap_en <= PWDATA[CC_IAP_EN];
		end
	end

	// Boot block is latched from boot select as the reset releases, so the config bit never reaches it directly.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			BOOT_LOADER <= ~CFG_RESET[CFG_BOOT_DEFAULT];
		end else if (hold_done) begin
			BOOT_LOADER <= boot_sel; // [R7] [R11]
		end
	end

	// Core load values held on flops; the core takes them while reset stands.
	always_ff @(posedge REF_CLK) begin
		if (RST || SYS_RESET) begin
			FETCH_ADDR <= FETCH_RESET; // [R13]
			STACK_INIT <= STACK_RESET; // [R14]
			PORT_LATCH <= PORT_RESET; // [R17]
		end
	end

	// Reset source flags. Software writes may set or clear them, but a hardware set wins the same cycle.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			soft_flag <= AUX_RESET[AUX_SOFT_FLAG];
			pin_flag <= AUX_RESET[AUX_PIN_FLAG];
			aux_rw <= AUX_RESET;
		end else begin
			if (trig_accept) begin
				soft_flag <= 1'b1; // [R5]
			end else if (wr && idx == IDX_AUX_FLAGS) begin
				soft_flag <= PWDATA[AUX_SOFT_FLAG]; // [R6]
			end
			if (pin_low) begin
				pin_flag <= 1'b1;
			end else if (wr && idx == IDX_AUX_FLAGS) begin
				pin_flag <= PWDATA[AUX_PIN_FLAG];
			end
			if (SYS_RESET) begin
				aux_rw <= AUX_RESET; // [R15]
			end else if (wr && idx == IDX_AUX_FLAGS) begin
				aux_rw <= PWDATA[7:0] & AUX_RW_MASK;
			end
		end
	end

	// Configuration byte is nonvolatile storage: only power-on restores its default.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			boot_cfg <= CFG_RESET; // [R10]
		end else if (wr && idx == IDX_BOOT_CONFIG) begin
			boot_cfg <= PWDATA[7:0];
		end
	end

	// RAM counts as valid only after software marks it; power-on clears the mark, other resets keep it.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ram_ok <= 1'b0; // [R12]
		end else if (wr && idx == IDX_CORE_STATE && PWDATA[CS_RAM_OK]) begin
			ram_ok <= 1'b1;
		end
	end

	// Interrupt events and sticky status; a read clears only the bits it returned.
	assign events[EV_SOFT_DONE] = hold_done & cause_soft;
	assign events[EV_PIN_RESET] = pin_low & (seq == SRB_RUN);
	assign events[EV_WDT_RESET] = WDT_TIMEOUT & (seq == SRB_RUN);
	assign events[EV_DENIED] = cc_wr & ~ta_open; // [R18]

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			irq_status <= '0;
		end else if (rd && idx == IDX_IRQ_STATUS) begin
			irq_status <= (irq_status & ~PRDATA[EV_W-1:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// Mask falls back to zero on every reset so all sources start disabled.
	always_ff @(posedge REF_CLK) begin
		if (RST || SYS_RESET) begin
			irq_mask <= '0; // [R16]
		end else if (wr && idx == IDX_IRQ_MASK) begin
			irq_mask <= PWDATA[EV_W-1:0];
		end
	end

	// Read multiplexer; the trigger bit is write-only and reads as zero.
	always_comb begin
		rd_mux = 8'h00;
		unique case (idx)
			IDX_CHIP_CONTROL: begin
				rd_mux[CC_IAP_FAIL] = iap_fail;
				rd_mux[CC_BOOT_SEL] = boot_sel;
				rd_mux[CC_IAP_EN] = iap_en;
			end
			IDX_AUX_FLAGS: begin
				rd_mux = aux_rw;
				rd_mux[AUX_SOFT_FLAG] = soft_flag;
				rd_mux[AUX_PIN_FLAG] = pin_flag;
			end
			IDX_BOOT_CONFIG: rd_mux = boot_cfg;
			IDX_IRQ_STATUS: rd_mux[EV_W-1:0] = irq_status;
			IDX_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask;
			IDX_CORE_STATE: begin
				rd_mux[CS_RAM_OK] = ram_ok;
				rd_mux[CS_TA_OPEN] = ta_open;
				rd_mux[CS_SOFT_CAUSE] = cause_soft;
				rd_mux[CS_IN_RESET] = SYS_RESET;
			end
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop in the access cycle.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE) begin
			PRDATA <= {24'h00_0000, rd_mux};
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	a_trigger_starts_reset: assert property (trig_accept && !enter_hw |=> SYS_RESET && cause_soft) // [R1]
		else $error("accepted trigger did not start a soft reset");
	a_hold_length: assert property ($rose(SYS_RESET) && !pin_low && !WDT_TIMEOUT |-> SYS_RESET[*8]) // [R1]
		else $error("reset released too early");
	a_stall_on_trigger: assert property (trig_accept |-> CORE_STALL ##1 CORE_STALL) // [R3]
		else $error("core not stalled by trigger");
	a_trigger_self_clear: assert property (hold_done && !enter_hw |=> !SYS_RESET && !trigger) // [R4]
		else $error("trigger not cleared at reset end");
	a_flag_set_soft: assert property (trig_accept |=> soft_flag) // [R5]
		else $error("soft reset flag not set");
	a_flag_kept_hw: assert property (enter_hw && !trig_accept && !(wr && idx == IDX_AUX_FLAGS)
		|=> soft_flag == $past(soft_flag)) // [R6]
		else $error("soft reset flag changed by hardware reset");
	a_soft_keeps_boot: assert property (SYS_RESET && cause_soft && !enter_hw |=> $stable(boot_sel)) // [R8]
		else $error("boot select changed by soft reset");
	a_hw_loads_boot: assert property (enter_hw |=> boot_sel == ~$past(boot_cfg[CFG_BOOT_DEFAULT])) // [R9]
		else $error("boot select not loaded from inverted config bit");
	a_boot_at_release: assert property ($fell(SYS_RESET) |-> BOOT_LOADER == $past(boot_sel)) // [R11]
		else $error("boot block not taken from boot select");
	a_locked_ignored: assert property (cc_wr && !ta_open && seq == SRB_RUN && !enter_hw |=> !SYS_RESET) // [R18]
		else $error("locked trigger write caused a reset");
	a_reset_values: assert property (SYS_RESET ##1 SYS_RESET |-> FETCH_ADDR == FETCH_RESET
		&& STACK_INIT == STACK_RESET && PORT_LATCH == PORT_RESET) // [R13]
		else $error("core load values wrong during reset");
	a_irq_quiet_reset: assert property (SYS_RESET ##1 SYS_RESET |-> !IRQ) // [R16]
		else $error("interrupt raised during reset");
endmodule : srb_top
`default_nettype wire

/* File: tb/srb_top_tb.sv */
// Self-checking testbench for the software reset and boot select block.
`timescale 1ns/1ps
`default_nettype none
module srb_top_tb;
	import srb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic ext_reset_n = 1'b1;
	logic wdt_timeout = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, sys_reset, core_stall, boot_loader, port_input_only, periph_disable, ram_valid, irq;
	logic [15:0] fetch_addr;
	logic [7:0] stack_init, port_latch;
	int err_count = 0;
	int compares = 0;
	int len;

	srb_top dut (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_RESET_N(ext_reset_n), .WDT_TIMEOUT(wdt_timeout), .SYS_RESET(sys_reset),
		.CORE_STALL(core_stall), .BOOT_LOADER(boot_loader), .FETCH_ADDR(fetch_addr),
		.STACK_INIT(stack_init), .PORT_LATCH(port_latch), .PORT_INPUT_ONLY(port_input_only),
		.PERIPH_DISABLE(periph_disable), .RAM_VALID(ram_valid), .IRQ(irq));

	// Free-running system clock.
	always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

	// Compares one observed value against its expectation and logs any difference.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t %s: saw %h, expected %h", $time, what, seen, exp);
		end
	endtask : check

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) check(32'h0, 32'h1, "pready never came");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, idx, wd, rd, err);
	endtask : wr

	// Reads a register and checks both data and error response.
	task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic err;
		xfer(1'b0, idx, 8'h00, rd, err);
		check(rd, exp, "read data");
		check({31'h0, err}, {31'h0, exp_err}, "slave error");
	endtask : rdchk

	// Opens the timed window with the two key writes.
	task automatic unlock();
		wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
		wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
	endtask : unlock

	// Waits for a system reset, checks the held outputs once, and returns its length in cycles.
	task automatic wait_reset(output int len);
		int n;
		n = 0;
		len = 0;
		while (sys_reset !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		check({31'h0, sys_reset}, 32'h1, "system reset not raised");
		check({16'h0, fetch_addr}, {16'h0, FETCH_RESET}, "fetch address");
		check({24'h0, stack_init}, {24'h0, STACK_RESET}, "stack load");
		check({24'h0, port_latch}, {24'h0, PORT_RESET}, "port latch");
		check({29'h0, port_input_only, periph_disable, core_stall}, 32'h7, "held outputs");
		while (sys_reset === 1'b1 && len < 200) begin
			@(posedge ref_clk);
			len++;
		end
	endtask : wait_reset

	// Watchdog: the tests need well under a thousand cycles.
	initial begin
		#(CLK_PERIOD_NS * 10000);
		err_count++;
		results();
	end

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// Main sequence.
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		// Values after power-on reset with a blank configuration byte.
		rdchk(IDX_BOOT_CONFIG, 32'hff, 1'b0);
		rdchk(IDX_CHIP_CONTROL, 32'h00, 1'b0);
		rdchk(IDX_AUX_FLAGS, 32'h00, 1'b0);
		check({31'h0, boot_loader}, 32'h0, "boot block after power-on");
		check({31'h0, ram_valid}, 32'h0, "ram after power-on");
		rdchk(10'h0c0, 32'h00, 1'b1);
		wr(IDX_CORE_STATE, 8'h01);
		// A trigger without the window is ignored and raises the denied event.
		wr(IDX_CHIP_CONTROL, 8'h80);
		@(posedge ref_clk);
		check({31'h0, sys_reset}, 32'h0, "reset without window");
		rdchk(IDX_IRQ_STATUS, 32'h08, 1'b0);
		rdchk(IDX_IRQ_STATUS, 32'h00, 1'b0);
		wr(IDX_IRQ_MASK, 8'h08);
		wr(IDX_CHIP_CONTROL, 8'h80);
		@(posedge ref_clk);
		check({31'h0, irq}, 32'h1, "irq on unmasked event");
		rdchk(IDX_IRQ_STATUS, 32'h08, 1'b0);
		@(posedge ref_clk);
		check({31'h0, irq}, 32'h0, "irq after clear");
		// Select the loader block, then trigger a software reset.
		unlock();
		wr(IDX_CHIP_CONTROL, 8'h02);
		rdchk(IDX_CHIP_CONTROL, 32'h02, 1'b0);
		unlock();
		wr(IDX_CHIP_CONTROL, 8'h82);
		wait_reset(len);
		check(len, 8, "soft reset length");
		rdchk(IDX_CHIP_CONTROL, 32'h02, 1'b0);
		check({31'h0, boot_loader}, 32'h1, "boot block after soft reset");
		rdchk(IDX_AUX_FLAGS, 32'h80, 1'b0);
		rdchk(IDX_IRQ_STATUS, 32'h01, 1'b0);
		rdchk(IDX_IRQ_MASK, 32'h00, 1'b0);
		rdchk(IDX_CORE_STATE, 32'h05, 1'b0);
		check({31'h0, ram_valid}, 32'h1, "ram after soft reset");
		// Watchdog reset with config bit one reloads boot select to zero.
		@(posedge ref_clk);
		wdt_timeout <= 1'b1;
		@(posedge ref_clk);
		wdt_timeout <= 1'b0;
		wait_reset(len);
		check(len, 8, "watchdog reset length");
		rdchk(IDX_CHIP_CONTROL, 32'h00, 1'b0);
		check({31'h0, boot_loader}, 32'h0, "boot block after watchdog reset");
		rdchk(IDX_AUX_FLAGS, 32'h80, 1'b0);
		rdchk(IDX_IRQ_STATUS, 32'h04, 1'b0);
		rdchk(IDX_CORE_STATE, 32'h01, 1'b0);
		// Pin reset with config bit zero selects the loader block.
		wr(IDX_BOOT_CONFIG, 8'h7f);
		@(posedge ref_clk);
		ext_reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		ext_reset_n <= 1'b1;
		wait_reset(len);
		rdchk(IDX_CHIP_CONTROL, 32'h02, 1'b0);
		check({31'h0, boot_loader}, 32'h1, "boot block after pin reset");
		rdchk(IDX_AUX_FLAGS, 32'hc0, 1'b0);
		rdchk(IDX_BOOT_CONFIG, 32'h7f, 1'b0);
		rdchk(IDX_IRQ_STATUS, 32'h02, 1'b0);
		check({31'h0, ram_valid}, 32'h1, "ram after pin reset");
		// Writable aux bits take ones, the two fixed bits stay zero.
		wr(IDX_AUX_FLAGS, 8'hff);
		rdchk(IDX_AUX_FLAGS, 32'hf9, 1'b0);
		wr(IDX_AUX_FLAGS, 8'h00);
		rdchk(IDX_AUX_FLAGS, 32'h00, 1'b0);
		// A second power-on reset drops the RAM mark and restores the blank configuration byte.
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		check({31'h0, ram_valid}, 32'h0, "ram after second power-on");
		check({31'h0, boot_loader}, 32'h0, "boot block after second power-on");
		rdchk(IDX_BOOT_CONFIG, 32'hff, 1'b0);
		rdchk(IDX_CHIP_CONTROL, 32'h00, 1'b0);
		results();
	end
endmodule : srb_top_tb
`default_nettype wire
